//--- src/sps_pkg.sv
// sps_pkg: register map, command codes, field positions and timing
// assumes a 40 MHz ref_clk and a 32-bit Avalon-MM slave port
package sps_pkg;
  // register byte offsets
  localparam logic [4:0] REG_CMD    = 5'h00;
  localparam logic [4:0] REG_ADDR   = 5'h04;
  localparam logic [4:0] REG_WDATA  = 5'h08;
  localparam logic [4:0] REG_RDATA  = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_CONFIG = 5'h14;
  localparam logic [4:0] REG_PWD_LO = 5'h18;
  localparam logic [4:0] REG_PWD_HI = 5'h1C;

  // command codes written to REG_CMD
  localparam logic [3:0] CMD_ENTER_OTP  = 4'h1;
  localparam logic [3:0] CMD_ENTER_NV   = 4'h2;
  localparam logic [3:0] CMD_EXIT       = 4'h3;
  localparam logic [3:0] CMD_PROG       = 4'h4;
  localparam logic [3:0] CMD_ERASE      = 4'h5;
  localparam logic [3:0] CMD_READ       = 4'h6;
  localparam logic [3:0] CMD_DYN_SET    = 4'h7;
  localparam logic [3:0] CMD_DYN_CLR    = 4'h8;
  localparam logic [3:0] CMD_GUARD_CLR  = 4'h9;
  localparam logic [3:0] CMD_PWD_UNLOCK = 4'hA;
  localparam logic [3:0] CMD_SOFT_RESET = 4'hB;
  localparam logic [3:0] CMD_PWD_STORE  = 4'hC;

  // status word bits
  localparam int ST_GRANT  = 0;
  localparam int ST_LOCKED = 1;
  localparam int ST_ERSERR = 5;
  localparam int ST_PRGERR = 4;
  localparam int ST_READY  = 7;

  // config register bits
  localparam int CFG_GUARD   = 0;
  localparam int CFG_SCHEME  = 1;
  localparam int CFG_FREEZE  = 10;

  // scheme field values
  localparam logic [1:0] SCH_NONE     = 2'h0;
  localparam logic [1:0] SCH_PASSWORD = 2'h1;
  localparam logic [1:0] SCH_PERSIST  = 2'h2;
  localparam logic [1:0] SCH_TEMP     = 2'h3;

  // secure region layout, in 16-bit words
  localparam int OTP_WORDS     = 512;
  localparam int OTP_AW        = 9;
  localparam int OTP_RAND_TOP  = 8;
  localparam int OTP_LOCK_WORD = 8;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [127:0] RANDOM_DEFAULT = 128'h5A3C_96E1_0F7B_24D8_C1A9_6E53_B702_8F4D;

  localparam int SECTORS = 256;
  localparam int SEC_AW  = 8;

  // timing
  localparam int CLK_MHZ     = 40;
  localparam int NV_PROG_US  = 500;
  localparam int NV_ERASE_MS = 930;
  localparam int CNT_W       = 26;

  typedef enum logic [2:0] {
    OVL_ARRAY = 3'b001,
    OVL_OTP   = 3'b010,
    OVL_NV    = 3'b100
  } sps_ovl_t;

  typedef enum logic [2:0] {
    PE_IDLE  = 3'b001,
    PE_PROG  = 3'b010,
    PE_ERASE = 3'b100
  } sps_pe_t;
endpackage

//--- src/sps_protect_ctrl.sv
// sps_protect_ctrl: secure OTP region and sector protection control
// assumes an Avalon-MM master on ref_clk; hwReset is a synchronous pulse
//
// How it works
// - secure words reprogrammable, never erasable
// - same program command, inside secure overlay
// - secure address bits nine upward ignored
// - freeze zero: secure program silently dropped
// - secure region gated by freeze, lock bits and random range
// - exit returns to normal array mode
// - lock bytes, one bit per region
// - reserved bytes delivered as all ones
// - sector blocked if either bit zero
// - guard zero shields all nonvolatile bits
// - persistent: reset sets guard, soft keeps
// - persistent: clear only, no command sets
// - password: reset clears guard
// - password: exact match sets guard
// - password: clear command works whenever no nv operation is busy
// - scheme fixed by one-time config bits
// - nonvolatile bits program singly, erase together
// - status readable, reports busy completion
// - guarded attempt aborts, flags status error
// - nonvolatile overlay read gives sector bit
// - dynamic set protects, clear unprotects
// - zeros into random number fail, flag
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module sps_protect_ctrl #(
  parameter int unsigned NV_PROG_CYC  = sps_pkg::NV_PROG_US * sps_pkg::CLK_MHZ,
  parameter int unsigned NV_ERASE_CYC = sps_pkg::NV_ERASE_MS * 1000 * sps_pkg::CLK_MHZ
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        hwReset,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             nvBusy,
  output logic             lockGuard,
  output logic      [2:0]  overlayMode
);

  typedef struct packed {
    logic                                         waitReq;
    logic                                         busy;
    logic [31:0]                                  rdBus;
    sps_pkg::sps_ovl_t                            ovl;
    sps_pkg::sps_pe_t                             pe;
    logic [sps_pkg::CNT_W-1:0]                    cnt;
    logic [sps_pkg::SEC_AW-1:0]                   peSector;
    logic [15:0]                                  addr;
    logic [15:0]                                  wdata;
    logic [15:0]                                  rdata;
    logic [7:0]                                   status;
    logic                                         guard;
    logic [1:0]                                   scheme;
    logic                                         freeze;
    logic [63:0]                                  hidden;
    logic [63:0]                                  cand;
    logic [sps_pkg::SECTORS-1:0]                  nvBits;
    logic [sps_pkg::SECTORS-1:0]                  dynBits;
    logic [sps_pkg::OTP_WORDS-1:0][15:0]          otp;
  } sps_state_t;

  sps_state_t s_q;
  sps_state_t s_d;

  function automatic logic [sps_pkg::OTP_WORDS-1:0][15:0] otpDelivered();
    logic [sps_pkg::OTP_WORDS-1:0][15:0] m;
    for (int i = 0; i < sps_pkg::OTP_WORDS; i++) begin
      m[i] = sps_pkg::ERASED_WORD;
    end
    for (int i = 0; i < sps_pkg::OTP_RAND_TOP; i++) begin
      m[i] = sps_pkg::RANDOM_DEFAULT[i*16 +: 16];
    end
    return m;
  endfunction

  function automatic logic sectorOpen(logic nvBit, logic dynBit);
    return nvBit & dynBit;
  endfunction

  function automatic logic [sps_pkg::CNT_W-1:0] cycles(int unsigned n);
    int unsigned m;
    m = n - 1;
    return m[sps_pkg::CNT_W-1:0];
  endfunction

  logic req;
  assign req = avs_read | avs_write;

  always_comb begin
    logic [sps_pkg::OTP_AW-1:0]  widx;
    logic [4:0]                  region;
    logic [15:0]                 lockWord;
    logic [sps_pkg::SEC_AW-1:0]  sec;
    logic [3:0]                  cmd;
    logic [1:0]                  newSch;
    logic [31:0]                 rmux;
    logic                        idle;
    widx     = s_q.addr[sps_pkg::OTP_AW-1:0];
    region   = widx[sps_pkg::OTP_AW-1:4];
    lockWord = s_q.otp[sps_pkg::OTP_LOCK_WORD + int'(region[4])];
    sec      = s_q.addr[sps_pkg::SEC_AW-1:0];
    cmd      = avs_writedata[3:0];
    newSch   = avs_writedata[sps_pkg::CFG_SCHEME +: 2];
    rmux     = 32'h0000_0000;
    idle     = (s_q.pe == sps_pkg::PE_IDLE);
    s_d      = s_q;

    // read mux
    case (avs_address)
      sps_pkg::REG_ADDR:   rmux = {16'h0000, s_q.addr};
      sps_pkg::REG_WDATA:  rmux = {16'h0000, s_q.wdata};
      sps_pkg::REG_RDATA:  rmux = {16'h0000, s_q.rdata};
      sps_pkg::REG_STATUS: rmux = {24'h00_0000, s_q.status};
      sps_pkg::REG_CONFIG: begin
        rmux[sps_pkg::CFG_GUARD]       = s_q.guard;
        rmux[sps_pkg::CFG_SCHEME +: 2] = s_q.scheme;
        rmux[sps_pkg::CFG_FREEZE]      = s_q.freeze;
      end
      default:             rmux = 32'h0000_0000;
    endcase

    // bus handshake: capture, then one cycle with waitrequest low
    if (req && s_q.waitReq) begin
      s_d.waitReq = 1'b0;
      s_d.rdBus   = avs_read ? rmux : 32'h0000_0000;
    end else if (req) begin
      s_d.waitReq = 1'b1;
    end

    // internal program/erase timer for nonvolatile bits
    case (s_q.pe)
      sps_pkg::PE_IDLE: begin
      end
      sps_pkg::PE_PROG: begin
        if (s_q.cnt == '0) begin
          s_d.nvBits[s_q.peSector] = 1'b0;
          s_d.pe                   = sps_pkg::PE_IDLE;
          s_d.status[sps_pkg::ST_READY] = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      sps_pkg::PE_ERASE: begin
        if (s_q.cnt == '0) begin
          s_d.nvBits = '1;
          s_d.pe     = sps_pkg::PE_IDLE;
          s_d.status[sps_pkg::ST_READY] = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      default: s_d.pe = sps_pkg::PE_IDLE;
    endcase

    // write commit on the cycle waitrequest is low
    if (avs_write && !s_q.waitReq) begin
      case (avs_address)
        sps_pkg::REG_ADDR:   s_d.addr = avs_writedata[15:0];
        sps_pkg::REG_WDATA:  s_d.wdata = avs_writedata[15:0];
        sps_pkg::REG_PWD_LO: s_d.cand[31:0] = avs_writedata;
        sps_pkg::REG_PWD_HI: s_d.cand[63:32] = avs_writedata;
        sps_pkg::REG_CONFIG: begin
          s_d.freeze = avs_writedata[sps_pkg::CFG_FREEZE];
          if (newSch != sps_pkg::SCH_TEMP) begin
            if (s_q.scheme != sps_pkg::SCH_TEMP || newSch == sps_pkg::SCH_NONE) begin
              s_d.status[sps_pkg::ST_PRGERR] = 1'b1;
              s_d.status[sps_pkg::ST_LOCKED] = 1'b1;
            end else begin
              s_d.scheme = newSch;
            end
          end
        end
        sps_pkg::REG_CMD: begin
          if (idle) begin
            s_d.status = 8'h80;
            case (cmd)
              sps_pkg::CMD_ENTER_OTP: s_d.ovl = sps_pkg::OVL_OTP;
              sps_pkg::CMD_ENTER_NV:  s_d.ovl = sps_pkg::OVL_NV;
              sps_pkg::CMD_EXIT:      s_d.ovl = sps_pkg::OVL_ARRAY;
              sps_pkg::CMD_SOFT_RESET: s_d.ovl = sps_pkg::OVL_ARRAY;
              sps_pkg::CMD_PROG: begin
                case (s_q.ovl)
                  sps_pkg::OVL_OTP: begin
                    if (!s_q.freeze) begin
                      s_d.status = 8'h80;
                    end else if (int'(widx) < sps_pkg::OTP_RAND_TOP &&
                                 s_q.wdata != sps_pkg::ERASED_WORD) begin
                      s_d.status[sps_pkg::ST_PRGERR] = 1'b1;
                    end else if (!lockWord[region[3:0]]) begin
                      s_d.status[sps_pkg::ST_PRGERR] = 1'b1;
                    end else begin
                      s_d.otp[widx] = s_q.otp[widx] & s_q.wdata;
                    end
                  end
                  sps_pkg::OVL_NV: begin
                    if (!s_q.guard) begin
                      s_d.status[sps_pkg::ST_PRGERR] = 1'b1;
                      s_d.status[sps_pkg::ST_LOCKED] = 1'b1;
                    end else begin
                      s_d.pe       = sps_pkg::PE_PROG;
                      s_d.peSector = sec;
                      s_d.cnt      = cycles(NV_PROG_CYC);
                      s_d.status[sps_pkg::ST_READY] = 1'b0;
                    end
                  end
                  sps_pkg::OVL_ARRAY: begin
                    if (sectorOpen(s_q.nvBits[sec], s_q.dynBits[sec])) begin
                      s_d.status[sps_pkg::ST_GRANT] = 1'b1;
                    end else begin
                      s_d.status[sps_pkg::ST_PRGERR] = 1'b1;
                    end
                  end
                  default: s_d.ovl = sps_pkg::OVL_ARRAY;
                endcase
              end
              sps_pkg::CMD_ERASE: begin
                case (s_q.ovl)
                  sps_pkg::OVL_OTP: s_d.status = 8'h80;
                  sps_pkg::OVL_NV: begin
                    if (!s_q.guard) begin
                      s_d.status[sps_pkg::ST_ERSERR] = 1'b1;
                      s_d.status[sps_pkg::ST_LOCKED] = 1'b1;
                    end else begin
                      s_d.pe  = sps_pkg::PE_ERASE;
                      s_d.cnt = cycles(NV_ERASE_CYC);
                      s_d.status[sps_pkg::ST_READY] = 1'b0;
                    end
                  end
                  sps_pkg::OVL_ARRAY: begin
                    if (sectorOpen(s_q.nvBits[sec], s_q.dynBits[sec])) begin
                      s_d.status[sps_pkg::ST_GRANT] = 1'b1;
                    end else begin
                      s_d.status[sps_pkg::ST_ERSERR] = 1'b1;
                    end
                  end
                  default: s_d.ovl = sps_pkg::OVL_ARRAY;
                endcase
              end
              sps_pkg::CMD_READ: begin
                case (s_q.ovl)
                  sps_pkg::OVL_OTP: s_d.rdata = s_q.otp[widx];
                  sps_pkg::OVL_NV:  s_d.rdata = {15'h0000, s_q.nvBits[sec]};
                  sps_pkg::OVL_ARRAY: begin
                    s_d.rdata = {14'h0000, s_q.nvBits[sec], s_q.dynBits[sec]};
                  end
                  default: s_d.rdata = 16'h0000;
                endcase
              end
              sps_pkg::CMD_DYN_SET: s_d.dynBits[sec] = 1'b0;
              sps_pkg::CMD_DYN_CLR: s_d.dynBits[sec] = 1'b1;
              sps_pkg::CMD_GUARD_CLR: s_d.guard = 1'b0;
              sps_pkg::CMD_PWD_UNLOCK: begin
                if (s_q.scheme == sps_pkg::SCH_PASSWORD && s_q.cand == s_q.hidden) begin
                  s_d.guard = 1'b1;
                end
              end
              sps_pkg::CMD_PWD_STORE: begin
                if (s_q.scheme == sps_pkg::SCH_TEMP) begin
                  s_d.hidden = s_q.hidden & s_q.cand;
                end else begin
                  s_d.status[sps_pkg::ST_PRGERR] = 1'b1;
                end
              end
              default: s_d.status = 8'h80;
            endcase
          end
        end
        default: s_d.waitReq = 1'b1;
      endcase
    end

    // hardware reset: volatile state only
    if (hwReset) begin
      s_d.ovl     = sps_pkg::OVL_ARRAY;
      s_d.pe      = sps_pkg::PE_IDLE;
      s_d.status  = 8'h80;
      s_d.dynBits = '1;
      s_d.freeze  = 1'b1;
      s_d.guard   = (s_q.scheme != sps_pkg::SCH_PASSWORD);
    end

    // registered busy flag so nvBusy leaves a flop
    s_d.busy = (s_d.pe != sps_pkg::PE_IDLE);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.waitReq  <= 1'b1;
      s_q.busy     <= 1'b0;
      s_q.rdBus    <= 32'h0000_0000;
      s_q.ovl      <= sps_pkg::OVL_ARRAY;
      s_q.pe       <= sps_pkg::PE_IDLE;
      s_q.cnt      <= '0;
      s_q.peSector <= '0;
      s_q.addr     <= 16'h0000;
      s_q.wdata    <= 16'hFFFF;
      s_q.rdata    <= 16'h0000;
      s_q.status   <= 8'h80;
      s_q.guard    <= 1'b1;
      s_q.scheme   <= sps_pkg::SCH_TEMP;
      s_q.freeze   <= 1'b1;
      s_q.hidden   <= 64'hFFFF_FFFF_FFFF_FFFF;
      s_q.cand     <= 64'h0000_0000_0000_0000;
      s_q.nvBits   <= '1;
      s_q.dynBits  <= '1;
      s_q.otp      <= otpDelivered();
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.rdBus;
  assign avs_waitrequest = s_q.waitReq;
  assign nvBusy          = s_q.busy;
  assign lockGuard       = s_q.guard;
  assign overlayMode     = s_q.ovl;

endmodule
`default_nettype wire

//--- sim/sps_protect_ctrl_assertions.sv
// sps_protect_ctrl_assertions: port checks on the protection block
// assumes binding onto sps_protect_ctrl, one clock, async rst_n
`timescale 1ns/1ps
`default_nettype none
module sps_protect_ctrl_assertions #(
  parameter int unsigned NV_PROG_CYC  = 5,
  parameter int unsigned NV_ERASE_CYC = 9
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        hwReset,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        nvBusy,
  input wire logic        lockGuard,
  input wire logic [2:0]  overlayMode
);
  logic [31:0] busyCnt;
  logic        cmdOk;
  logic        unlk;
  assign cmdOk = avs_write && !avs_waitrequest && avs_address == sps_pkg::REG_CMD
                 && !nvBusy && !hwReset;
  assign unlk = avs_write && avs_address == sps_pkg::REG_CMD
                && avs_writedata[3:0] == sps_pkg::CMD_PWD_UNLOCK;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busyCnt <= 32'h0;
    end else begin
      busyCnt <= nvBusy ? busyCnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer to request");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_why; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
  a_why: assert property (p_why) else $error("answer without request");
  property p_hot; $onehot(overlayMode); endproperty
  a_hot: assert property (p_hot) else $error("overlay not one-hot");
  property p_exit; cmdOk && avs_writedata[3:0] == sps_pkg::CMD_EXIT |=> overlayMode == 3'h1;
  endproperty
  a_exit: assert property (p_exit) else $error("exit did not reach array mode");
  property p_otp; cmdOk && avs_writedata[3:0] == sps_pkg::CMD_ENTER_OTP |=> overlayMode == 3'h2;
  endproperty
  a_otp: assert property (p_otp) else $error("secure overlay not entered");
  property p_gclr; cmdOk && avs_writedata[3:0] == sps_pkg::CMD_GUARD_CLR |=> !lockGuard;
  endproperty
  a_gclr: assert property (p_gclr) else $error("guard clear failed");
  property p_grise; $rose(lockGuard) |-> $past(hwReset) || $past(unlk) || $past(unlk, 2);
  endproperty
  a_grise: assert property (p_grise) else $error("guard set without cause");
  property p_bsy; $rose(nvBusy) |-> lockGuard; endproperty
  a_bsy: assert property (p_bsy) else $error("nv operation with guard low");
  property p_len; nvBusy |-> busyCnt < NV_ERASE_CYC + 2; endproperty
  a_len: assert property (p_len) else $error("nv operation too long");
  property p_ref; nvBusy && avs_write && avs_address == sps_pkg::REG_CMD && !hwReset
    |=> $stable(overlayMode); endproperty
  a_ref: assert property (p_ref) else $error("command taken while busy");
  c_unlk: cover property (cmdOk && unlk);
  c_busy: cover property ($rose(nvBusy));
  c_gfall: cover property ($fell(lockGuard));
endmodule
bind sps_protect_ctrl sps_protect_ctrl_assertions #(
  .NV_PROG_CYC(NV_PROG_CYC), .NV_ERASE_CYC(NV_ERASE_CYC)
) u_chk (
  .ref_clk, .rst_n, .hwReset, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .nvBusy, .lockGuard, .overlayMode
);
`default_nettype wire

//--- sim/sps_host_model.sv
// sps_host_model: Avalon-MM master standing in for the host controller
// assumes one ref_clk; a request holds until waitrequest samples low
`timescale 1ns/1ps
`default_nettype none
module sps_host_model (
  input  wire logic        ref_clk,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  output var  logic [4:0]  avs_address,
  output var  logic        avs_read,
  output var  logic        avs_write,
  output var  logic [31:0] avs_writedata
);
  logic hang;
  initial begin
    hang = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= w ? d : 32'h0;
    avs_write <= w;
    avs_read <= !w;
    for (n = 0; n < 64; n++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 64) begin
      $display("BAD %0t: no answer", $time);
      hang = 1'b1;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- sim/test_sps_protect_ctrl.sv
// test_sps_protect_ctrl: self-checking bench for the protection block
// assumes sps_host_model as bus master, shortened nv timing
`timescale 1ns/1ps
`default_nettype none
module test_sps_protect_ctrl;
  logic        ref_clk, rst_n, hwReset, avs_read, avs_write, avs_waitrequest;
  logic        nvBusy, lockGuard;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0]  overlayMode;
  int          numErrors, nCompared, i;
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  sps_protect_ctrl #(.NV_PROG_CYC(5), .NV_ERASE_CYC(9)) u_dut (.ref_clk, .rst_n, .hwReset,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .nvBusy, .lockGuard, .overlayMode);
  sps_host_model u_host (.ref_clk, .avs_readdata, .avs_waitrequest, .avs_address,
    .avs_read, .avs_write, .avs_writedata);
  task automatic wrapUp;
    $display("errors %0d compares %0d", numErrors, nCompared);
    if (numErrors == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (u_host.hang) begin
      numErrors++;
      wrapUp();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_host.xfer(1'b1, a, d, x);
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [4:0] a);
    u_host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic cmd(input logic [3:0] c);
    wr(sps_pkg::REG_CMD, {28'h0, c});
  endtask
  task automatic op(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d);
    wr(sps_pkg::REG_ADDR, a);
    wr(sps_pkg::REG_WDATA, d);
    cmd(c);
  endtask
  task automatic look(input logic [31:0] a);
    op(sps_pkg::CMD_READ, a, 32'h0);
    rd(sps_pkg::REG_RDATA);
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    rd(sps_pkg::REG_STATUS);
    chk(q & m, e);
  endtask
  task automatic wait_idle;
    for (i = 0; i < 100 && nvBusy !== 1'b0; i++) @(posedge ref_clk);
    if (nvBusy !== 1'b0) begin
      $display("BAD %0t: busy hang", $time);
      numErrors++;
      wrapUp();
    end
  endtask
  task automatic hw;
    @(posedge ref_clk);
    hwReset <= 1'b1;
    @(posedge ref_clk);
    hwReset <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic t_reset;
    chk({31'h0, lockGuard}, 32'h1);
    chk({29'h0, overlayMode}, 32'h1);
    rd(sps_pkg::REG_CONFIG);
    chk(q & 32'h406, 32'h406);
  endtask
  task automatic t_otp;
    cmd(sps_pkg::CMD_ENTER_OTP);
    chk({29'h0, overlayMode}, 32'h2);
    op(sps_pkg::CMD_PROG, 32'h220, 32'h1234);
    look(32'h20);
    chk(q, 32'h1234);
    op(sps_pkg::CMD_PROG, 32'h20, 32'hFF00);
    op(sps_pkg::CMD_ERASE, 32'h20, 32'h0);
    look(32'h20);
    chk(q, 32'h1200);
    for (int k = 10; k < 16; k++) begin
      look(k);
      chk(q, 32'hFFFF);
    end
    op(sps_pkg::CMD_PROG, 32'h0, 32'h0);
    st(32'h10, 32'h10);
    op(sps_pkg::CMD_PROG, 32'h8, 32'hFFFB);
    op(sps_pkg::CMD_PROG, 32'h25, 32'h0);
    st(32'h10, 32'h10);
    look(32'h25);
    chk(q, 32'hFFFF);
    op(sps_pkg::CMD_PROG, 32'h30, 32'h00AA);
    st(32'h10, 32'h0);
    look(32'h30);
    chk(q, 32'h00AA);
    wr(sps_pkg::REG_CONFIG, 32'h6);
    op(sps_pkg::CMD_PROG, 32'h31, 32'h0);
    st(32'h10, 32'h0);
    look(32'h31);
    chk(q, 32'hFFFF);
    wr(sps_pkg::REG_CONFIG, 32'h406);
    cmd(sps_pkg::CMD_EXIT);
    chk({29'h0, overlayMode}, 32'h1);
  endtask
  task automatic t_sect;
    cmd(sps_pkg::CMD_ENTER_NV);
    op(sps_pkg::CMD_PROG, 32'h5, 32'h0);
    @(posedge ref_clk);
    chk({31'h0, nvBusy}, 32'h1);
    cmd(sps_pkg::CMD_EXIT);
    chk({29'h0, overlayMode}, 32'h4);
    wait_idle;
    st(32'h80, 32'h80);
    look(32'h5);
    chk(q, 32'h0);
    look(32'h6);
    chk(q, 32'h1);
    cmd(sps_pkg::CMD_EXIT);
    op(sps_pkg::CMD_PROG, 32'h5, 32'h0);
    st(32'h11, 32'h10);
    op(sps_pkg::CMD_DYN_SET, 32'h6, 32'h0);
    op(sps_pkg::CMD_PROG, 32'h6, 32'h0);
    st(32'h11, 32'h10);
    op(sps_pkg::CMD_DYN_CLR, 32'h6, 32'h0);
    op(sps_pkg::CMD_PROG, 32'h6, 32'h0);
    st(32'h11, 32'h1);
    cmd(sps_pkg::CMD_ENTER_NV);
    op(sps_pkg::CMD_ERASE, 32'h0, 32'h0);
    wait_idle;
    look(32'h5);
    chk(q, 32'h1);
    cmd(sps_pkg::CMD_GUARD_CLR);
    chk({31'h0, lockGuard}, 32'h0);
    op(sps_pkg::CMD_PROG, 32'h7, 32'h0);
    st(32'h12, 32'h12);
    op(sps_pkg::CMD_ERASE, 32'h0, 32'h0);
    st(32'h22, 32'h22);
    look(32'h7);
    chk(q, 32'h1);
    cmd(sps_pkg::CMD_SOFT_RESET);
    chk({31'h0, lockGuard}, 32'h0);
    wr(sps_pkg::REG_PWD_LO, 32'hFFFFFFFF);
    wr(sps_pkg::REG_PWD_HI, 32'hFFFFFFFF);
    cmd(sps_pkg::CMD_PWD_UNLOCK);
    chk({31'h0, lockGuard}, 32'h0);
    hw();
    chk({31'h0, lockGuard}, 32'h1);
  endtask
  task automatic t_pwd;
    wr(sps_pkg::REG_PWD_LO, 32'hCAFE0123);
    wr(sps_pkg::REG_PWD_HI, 32'h89AB4567);
    cmd(sps_pkg::CMD_PWD_STORE);
    wr(sps_pkg::REG_CONFIG, 32'h402);
    hw();
    chk({31'h0, lockGuard}, 32'h0);
    wr(sps_pkg::REG_PWD_LO, 32'hCAFE0122);
    cmd(sps_pkg::CMD_PWD_UNLOCK);
    chk({31'h0, lockGuard}, 32'h0);
    wr(sps_pkg::REG_PWD_LO, 32'hCAFE0123);
    cmd(sps_pkg::CMD_PWD_UNLOCK);
    chk({31'h0, lockGuard}, 32'h1);
    cmd(sps_pkg::CMD_GUARD_CLR);
    chk({31'h0, lockGuard}, 32'h0);
    wr(sps_pkg::REG_CONFIG, 32'h404);
    st(32'h12, 32'h12);
    rd(sps_pkg::REG_CONFIG);
    chk(q & 32'h6, 32'h2);
  endtask
  initial begin
    numErrors = 0;
    nCompared = 0;
    rst_n = 1'b0;
    hwReset = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    t_reset;
    t_otp;
    t_sect;
    t_pwd;
    wrapUp;
  end
endmodule
`default_nettype wire
